// file: bench/apio_assembly_tb_top.sv
// Self-checking bench for the polled I/O frame assembly
`timescale 1ns/1ns
module apio_assembly_tb_top;
  import apio_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cons_byte0, cons_byte1, cons_byte2, cons_byte3;
  logic cons_valid;
  logic local_sel_pin = 1'b0;
  logic stall_detect = 1'b0;
  apio_stat_type meas_stat = '0;
  logic [7:0] prod_byte0, prod_byte1, prod_byte2, prod_byte3;
  apio_cmd_type act_cmd;
  apio_drive_type drive_mode;
  logic stall_latched;
  logic [15:0] expl_prod_path_len, expl_cons_path_len;
  int error_cnt = 0;
  int samples_checked = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  apio_master_model master_u (.core_clk(core_clk), .cons_byte0(cons_byte0),
    .cons_byte1(cons_byte1), .cons_byte2(cons_byte2), .cons_byte3(cons_byte3),
    .cons_valid(cons_valid));

  apio_assembly dut_u (.core_clk(core_clk), .rst(rst), .cons_byte0(cons_byte0),
    .cons_byte1(cons_byte1), .cons_byte2(cons_byte2), .cons_byte3(cons_byte3),
    .cons_valid(cons_valid), .local_sel_pin(local_sel_pin), .stall_detect(stall_detect),
    .meas_stat(meas_stat), .prod_byte0(prod_byte0), .prod_byte1(prod_byte1),
    .prod_byte2(prod_byte2), .prod_byte3(prod_byte3), .act_cmd(act_cmd),
    .drive_mode(drive_mode), .stall_latched(stall_latched),
    .expl_prod_path_len(expl_prod_path_len), .expl_cons_path_len(expl_cons_path_len));

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Send one frame, then judge decoded commands and drive state
  task automatic cmd_case(input logic [31:0] frm, input apio_cmd_type ec,
                          input apio_drive_type em);
    master_u.send(frm);
    wait_n(3);
    chk({12'h000, act_cmd}, {12'h000, ec});
    chk({30'h0, drive_mode}, {30'h0, em});
  endtask : cmd_case

  task automatic t_reset;
    chk({prod_byte3, prod_byte2, prod_byte1, prod_byte0}, 32'h0);
    chk({9'h000, act_cmd, drive_mode, stall_latched}, 32'h0);
    chk({expl_prod_path_len, expl_cons_path_len}, 32'h0);
  endtask : t_reset

  task automatic t_commands;
    cmd_case(32'hfc_fd_12_34, {16'h1234, 4'b1000}, APIO_ST_TARGET);
    cmd_case(32'h01_01_56_78, {16'h5678, 4'b1010}, APIO_ST_RETRACT);
    cmd_case(32'h02_01_9a_bc, {16'h9abc, 4'b1001}, APIO_ST_EXTEND);
    cmd_case(32'h03_01_00_01, {16'h0001, 4'b1011}, APIO_ST_RETRACT);
    cmd_case(32'h01_00_00_10, {16'h0010, 4'b0010}, APIO_ST_STOP);
  endtask : t_commands

  task automatic t_stall;
    stall_detect = 1'b1;
    wait_n(1);
    stall_detect = 1'b0;
    wait_n(3);
    chk({31'h0, stall_latched}, 32'h1);
    chk({24'h0, prod_byte2}, 32'h04);
    cmd_case(32'h00_02_00_10, {16'h0010, 4'b0100}, APIO_ST_STOP);
    chk({31'h0, stall_latched}, 32'h0);
    // Clear request still held: a new stall must win for its own cycle
    stall_detect = 1'b1;
    wait_n(1);
    chk({31'h0, stall_latched}, 32'h1);
    stall_detect = 1'b0;
    wait_n(1);
    chk({31'h0, stall_latched}, 32'h0);
  endtask : t_stall

  // Motor stall input is ignored; the latch drives that bit
  task automatic t_status;
    meas_stat = {16'hbeef, 7'b1101101};
    wait_n(3);
    chk({prod_byte3, prod_byte2, prod_byte1, prod_byte0}, 32'h05_12_be_ef);
    meas_stat = {16'h00a5, 7'b0010010};
    wait_n(3);
    chk({prod_byte3, prod_byte2, prod_byte1, prod_byte0}, 32'h02_08_00_a5);
    meas_stat = '0;
  endtask : t_status

  // Local mode: frames lose their command bits, target is kept
  task automatic t_local;
    local_sel_pin = 1'b1;
    wait_n(5);
    chk({24'h0, prod_byte2}, 32'h01);
    cmd_case(32'h01_03_ff_ff, {16'h0010, 4'b0000}, APIO_ST_STOP);
    local_sel_pin = 1'b0;
    wait_n(5);
    chk({24'h0, prod_byte2}, 32'h00);
  endtask : t_local

  task automatic stop_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    wait_n(16);
    t_reset();
    rst = 1'b0;
    t_commands();
    t_stall();
    t_status();
    t_local();
    stop_test();
  end

  // Watchdog: tests need well under 1000 cycles
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : apio_assembly_tb_top

// file: bench/apio_master_model.sv
// Network master model that sends consumed frames
`timescale 1ns/1ns
module apio_master_model (
  input wire logic core_clk,
  output logic [7:0] cons_byte0,
  output logic [7:0] cons_byte1,
  output logic [7:0] cons_byte2,
  output logic [7:0] cons_byte3,
  output logic cons_valid
);
  // Idle until the first frame
  initial begin
    cons_valid = 1'b0;
    {cons_byte3, cons_byte2, cons_byte1, cons_byte0} = 32'h0000_0000;
  end

  // command bits
  // Stale bytes are inverted so late sampling shows up
  task automatic send(input logic [31:0] frm);
    @(negedge core_clk);
    {cons_byte3, cons_byte2, cons_byte1, cons_byte0} = frm;
    cons_valid = 1'b1;
    @(negedge core_clk);
    cons_valid = 1'b0;
    {cons_byte3, cons_byte2, cons_byte1, cons_byte0} = ~frm;
  endtask : send
endmodule : apio_master_model

// file: common/apio_pkg.sv
// Package: frame layouts, bit positions and constants for the polled I/O assembly
package apio_pkg;
  // Frame geometry
  localparam int APIO_FRAME_BYTES = 4;
  localparam int APIO_POS_W = 16;
  // Consumed frame bit positions (byte 2 and byte 3)
  localparam int APIO_C2_RUN_BIT = 0;
  localparam int APIO_C2_CLR_BIT = 1;
  localparam int APIO_C3_RETR_BIT = 0;
  localparam int APIO_C3_EXTD_BIT = 1;
  // Produced frame bit positions
  localparam int APIO_P2_LOCAL_BIT = 0;
  localparam int APIO_P2_ERR_BIT = 1;
  localparam int APIO_P2_STALL_BIT = 2;
  localparam int APIO_P2_ILLEGAL_BIT = 3;
  localparam int APIO_P2_MEMF_BIT = 4;
  localparam int APIO_P3_RETR_BIT = 0;
  localparam int APIO_P3_EXTD_BIT = 1;
  localparam int APIO_P3_TOL_BIT = 2;
  // Explicit connection path lengths
  localparam logic [15:0] APIO_EXPL_PATH_LEN = 16'h0000;
  // Reset values
  localparam logic [15:0] APIO_POS_RST = 16'h0000;
  localparam logic [7:0] APIO_BYTE_RST = 8'h00;
  // Local/remote encoding
  localparam logic APIO_REMOTE = 1'b0;
  localparam logic APIO_LOCAL = 1'b1;

  typedef logic [7:0] apio_frame_type [APIO_FRAME_BYTES];

  // Decoded actuator commands
  typedef struct packed {
    logic [15:0] target_position;
    logic run_cmd;
    logic stall_clear_req;
    logic force_retract;
    logic force_extend;
  } apio_cmd_type;

  // Status reported back to the master
  typedef struct packed {
    logic [15:0] present_position;
    logic general_error;
    logic motor_stall;
    logic illegal_input;
    logic memory_fault;
    logic retract_limit_flag;
    logic extend_limit_flag;
    logic within_tolerance_flag;
  } apio_stat_type;

  // Drive-state machine
  typedef enum logic [1:0] {
    APIO_ST_STOP = 2'b00,
    APIO_ST_TARGET = 2'b01,
    APIO_ST_RETRACT = 2'b10,
    APIO_ST_EXTEND = 2'b11
  } apio_drive_type;
endpackage : apio_pkg

// file: verilog/apio_assembly.sv
// Polled I/O frame packer/unpacker for a network-driven linear actuator
//
// Behaviour
// - Target position: byte0 low, byte1 high
// - Byte2 bit0 is the run command
// - Byte2 bit1 requests stall latch clear
// - Byte3 bit0 forces full retract
// - Byte3 bit1 forces full extend
// - Present position: byte0 low, byte1 high
// - Byte2: local, error, stall, illegal, memory
// - Byte3: retract limit, extend limit, tolerance
// - Explicit path lengths both read zero
// - Selector drives local bit; local ignores network
// - Motion commands act only while run set
`timescale 1ns/1ns
module apio_assembly
  import apio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] cons_byte0,
  input wire logic [7:0] cons_byte1,
  input wire logic [7:0] cons_byte2,
  input wire logic [7:0] cons_byte3,
  input wire logic cons_valid,
  input wire logic local_sel_pin,
  input wire logic stall_detect,
  input wire apio_stat_type meas_stat,
  output logic [7:0] prod_byte0,
  output logic [7:0] prod_byte1,
  output logic [7:0] prod_byte2,
  output logic [7:0] prod_byte3,
  output apio_cmd_type act_cmd,
  output apio_drive_type drive_mode,
  output logic stall_latched,
  output logic [15:0] expl_prod_path_len,
  output logic [15:0] expl_cons_path_len
);
  // Selector switch is a pin: synchronise before use
  logic local_sync;

  apio_sync #(.W(1)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(local_sel_pin),
    .sync_out(local_sync)
  );

  apio_cmd_type cmd_q;
  apio_cmd_type cmd_d;
  apio_drive_type mode_q;
  apio_drive_type mode_d;
  logic stall_q;
  logic stall_d;
  logic [7:0] pb0_q, pb1_q, pb2_q, pb3_q;
  logic [7:0] pb0_d, pb1_d, pb2_d, pb3_d;

  // Command capture from consumed frame
  always_comb begin
    cmd_d = cmd_q;
    if (local_sync == APIO_LOCAL) begin
      cmd_d.run_cmd = 1'b0;
      cmd_d.stall_clear_req = 1'b0;
      cmd_d.force_retract = 1'b0;
      cmd_d.force_extend = 1'b0;
    end else if (cons_valid) begin
      cmd_d.target_position = {cons_byte1, cons_byte0};
      cmd_d.run_cmd = cons_byte2[APIO_C2_RUN_BIT];
      cmd_d.stall_clear_req = cons_byte2[APIO_C2_CLR_BIT];
      cmd_d.force_retract = cons_byte3[APIO_C3_RETR_BIT];
      cmd_d.force_extend = cons_byte3[APIO_C3_EXTD_BIT];
    end
  end

  // Drive mode and stall latch; set beats clear so no stall is lost
  always_comb begin
    mode_d = APIO_ST_STOP;
    stall_d = stall_q;
    if (cmd_q.stall_clear_req) begin
      stall_d = 1'b0;
    end
    if (stall_detect) begin
      stall_d = 1'b1;
    end
    if (cmd_q.run_cmd && local_sync == APIO_REMOTE) begin
      // Retract wins if both forced bits set, a safe-side choice
      if (cmd_q.force_retract) begin
        mode_d = APIO_ST_RETRACT;
      end else if (cmd_q.force_extend) begin
        mode_d = APIO_ST_EXTEND;
      end else begin
        mode_d = APIO_ST_TARGET;
      end
    end
  end

  // Produced frame packing
  always_comb begin
    pb0_d = meas_stat.present_position[7:0];
    pb1_d = meas_stat.present_position[15:8];
    pb2_d = APIO_BYTE_RST;
    pb3_d = APIO_BYTE_RST;
    pb2_d[APIO_P2_LOCAL_BIT] = local_sync;
    pb2_d[APIO_P2_ERR_BIT] = meas_stat.general_error;
    pb2_d[APIO_P2_STALL_BIT] = stall_q;
    pb2_d[APIO_P2_ILLEGAL_BIT] = meas_stat.illegal_input;
    pb2_d[APIO_P2_MEMF_BIT] = meas_stat.memory_fault;
    pb3_d[APIO_P3_RETR_BIT] = meas_stat.retract_limit_flag;
    pb3_d[APIO_P3_EXTD_BIT] = meas_stat.extend_limit_flag;
    pb3_d[APIO_P3_TOL_BIT] = meas_stat.within_tolerance_flag;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_q <= '0;
      mode_q <= APIO_ST_STOP;
      stall_q <= 1'b0;
      pb0_q <= APIO_BYTE_RST;
      pb1_q <= APIO_BYTE_RST;
      pb2_q <= APIO_BYTE_RST;
      pb3_q <= APIO_BYTE_RST;
      expl_prod_path_len <= APIO_EXPL_PATH_LEN;
      expl_cons_path_len <= APIO_EXPL_PATH_LEN;
    end else begin
      cmd_q <= cmd_d;
      mode_q <= mode_d;
      stall_q <= stall_d;
      pb0_q <= pb0_d;
      pb1_q <= pb1_d;
      pb2_q <= pb2_d;
      pb3_q <= pb3_d;
      expl_prod_path_len <= APIO_EXPL_PATH_LEN;
      expl_cons_path_len <= APIO_EXPL_PATH_LEN;
    end
  end

  assign act_cmd = cmd_q;
  assign drive_mode = mode_q;
  assign stall_latched = stall_q;
  assign prod_byte0 = pb0_q;
  assign prod_byte1 = pb1_q;
  assign prod_byte2 = pb2_q;
  assign prod_byte3 = pb3_q;

  // Assertions
  a_target_order: assert property (@(posedge core_clk) disable iff (rst)
    (cons_valid && local_sync == APIO_REMOTE) |=>
      act_cmd.target_position == {$past(cons_byte1), $past(cons_byte0)})
    else $error("target byte order wrong");
  a_run_decode: assert property (@(posedge core_clk) disable iff (rst)
    (cons_valid && local_sync == APIO_REMOTE) |=> act_cmd.run_cmd == $past(cons_byte2[0]))
    else $error("run bit not decoded");
  a_stall_clear: assert property (@(posedge core_clk) disable iff (rst)
    (act_cmd.stall_clear_req && !stall_detect) |=> !stall_latched)
    else $error("stall not cleared");
  a_retract_mode: assert property (@(posedge core_clk) disable iff (rst)
    (act_cmd.run_cmd && act_cmd.force_retract && local_sync == APIO_REMOTE)
      |=> drive_mode == APIO_ST_RETRACT)
    else $error("retract not forced");
  a_extend_mode: assert property (@(posedge core_clk) disable iff (rst)
    (act_cmd.run_cmd && !act_cmd.force_retract && act_cmd.force_extend
      && local_sync == APIO_REMOTE) |=> drive_mode == APIO_ST_EXTEND)
    else $error("extend not forced");
  a_pos_order: assert property (@(posedge core_clk) disable iff (rst)
    ##1 {prod_byte1, prod_byte0} == $past(meas_stat.present_position))
    else $error("position byte order wrong");
  a_stat_byte2: assert property (@(posedge core_clk) disable iff (rst)
    ##1 prod_byte2[4:0] == {$past(meas_stat.memory_fault), $past(meas_stat.illegal_input),
      $past(stall_latched), $past(meas_stat.general_error), $past(local_sync)})
    else $error("status byte 2 wrong");
  a_stat_byte3: assert property (@(posedge core_clk) disable iff (rst)
    ##1 prod_byte3[2:0] == {$past(meas_stat.within_tolerance_flag),
      $past(meas_stat.extend_limit_flag), $past(meas_stat.retract_limit_flag)})
    else $error("status byte 3 wrong");
  a_path_zero: assert property (@(posedge core_clk) disable iff (rst)
    expl_prod_path_len == 16'h0000 && expl_cons_path_len == 16'h0000)
    else $error("path length not zero");
  a_local_ignore: assert property (@(posedge core_clk) disable iff (rst)
    (local_sync == APIO_LOCAL) |=> !act_cmd.run_cmd ##1 drive_mode == APIO_ST_STOP)
    else $error("local mode obeyed network");
  a_run_gate: assert property (@(posedge core_clk) disable iff (rst)
    !act_cmd.run_cmd |=> drive_mode == APIO_ST_STOP)
    else $error("moved without run");
  a_zero_unused: assert property (@(posedge core_clk) disable iff (rst)
    prod_byte2[7:5] == 3'h0 && prod_byte3[7:3] == 5'h00)
    else $error("unassigned bits not zero");

  c_target_run: cover property (@(posedge core_clk) disable iff (rst)
    drive_mode == APIO_ST_TARGET);
  c_forced_ext: cover property (@(posedge core_clk) disable iff (rst)
    drive_mode == APIO_ST_EXTEND);
  c_stall_cycle: cover property (@(posedge core_clk) disable iff (rst)
    stall_latched ##[1:20] !stall_latched);
  c_local_mode: cover property (@(posedge core_clk) disable iff (rst)
    prod_byte2[0]);
endmodule : apio_assembly

// file: verilog/apio_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module apio_sync
  import apio_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage read only by the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : apio_sync
